// file: sbd_consts.vh
// Function
// - The scheme select level chooses address-latch strobe when low and address/data indicator when high, in either bus mode.
// - With select low at power-up, the address on the multiplexed bus is captured at each falling edge of the latch strobe.
// - The select level is taken at power-up; if high, the shared strobe pin is an address/data indicator used to interpret each write.
// - In indicator mode the indicator is sampled at the write strobe rising edge: high means address, low means data (split bus only).
`ifndef SBD_CONSTS_VH
`define SBD_CONSTS_VH
`define SBD_AD_W 8
`define SBD_ADDR_RST 8'h00
`define SBD_DATA_RST 8'h00
`define SBD_SCHEME_LATCH 1'b0
`define SBD_SCHEME_IND 1'b1
`endif

// file: sbd_edge.v
`timescale 1ns/1ps
`include "sbd_consts.vh"
// registers a pin level and reports its rising and falling edges
module sbd_edge
(
   input wire mclk_i,
   input wire rst_n_i,
   input wire pin_i,
   output wire rise_o,
   output wire fall_o
);
   reg last_ff;

   always @(posedge mclk_i)
   begin
      if (!rst_n_i)
         last_ff <= 1'b1;
      else
         last_ff <= pin_i;
   end

   assign rise_o = pin_i & ~last_ff;
   assign fall_o = ~pin_i & last_ff;
endmodule

// file: sbd_decode.v
`timescale 1ns/1ps
`include "sbd_consts.vh"
// address/data separation on the multiplexed bus
module sbd_decode
#(
   parameter AD_W = `SBD_AD_W
)
(
   input wire mclk_i,
   input wire rst_n_i,
   input wire split_bus_mode_i,
   input wire bus_scheme_select_i,
   input wire shared_strobe_pin_i,
   input wire wr_n_i,
   input wire [AD_W-1:0] ad_i,
   output wire scheme_o,
   output wire [AD_W-1:0] reg_addr_o,
   output wire addr_valid_o,
   output wire [AD_W-1:0] reg_data_o,
   output wire data_strobe_o
);
   reg scheme_ff;
   reg strap_done_ff;
   reg [AD_W-1:0] addr_ff;
   reg addr_valid_ff;
   reg [AD_W-1:0] data_ff;
   reg data_stb_ff;
   wire strb_fall;
   wire wr_rise;
   wire take_addr;
   wire take_data;

   sbd_edge u_strobe_edge
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i(shared_strobe_pin_i),
      .rise_o(),
      .fall_o(strb_fall)
   );

   sbd_edge u_wr_edge
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i(wr_n_i),
      .rise_o(wr_rise),
      .fall_o()
   );

   // strap caught once, at the first edge after reset release
   always @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         scheme_ff <= `SBD_SCHEME_IND;
         strap_done_ff <= 1'b0;
      end
      else if (!strap_done_ff)
      begin
         scheme_ff <= bus_scheme_select_i;
         strap_done_ff <= 1'b1;
      end
   end

   // latch scheme: falling strobe edge carries the address
   // indicator scheme: level at write rising edge picks addr/data
   assign take_addr = strap_done_ff &
      ((scheme_ff == `SBD_SCHEME_LATCH) ? strb_fall
       : (wr_rise & shared_strobe_pin_i));
   assign take_data = strap_done_ff & split_bus_mode_i & wr_rise &
      ((scheme_ff == `SBD_SCHEME_LATCH) | ~shared_strobe_pin_i);

   always @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         addr_ff <= `SBD_ADDR_RST;
         addr_valid_ff <= 1'b0;
         data_ff <= `SBD_DATA_RST;
         data_stb_ff <= 1'b0;
      end
      else
      begin
         if (take_addr)
         begin
            addr_ff <= ad_i;
            addr_valid_ff <= 1'b1;
         end
         data_stb_ff <= take_data;
         if (take_data)
            data_ff <= ad_i;
      end
   end

   assign scheme_o = scheme_ff;
   assign reg_addr_o = addr_ff; // held for all data bytes
   assign addr_valid_o = addr_valid_ff;
   assign reg_data_o = data_ff;
   assign data_strobe_o = data_stb_ff;
endmodule

// file: sbd_decode_assertions.sv
`timescale 1ns/1ps
module sbd_chk(input wire mclk_i,rst_n_i,split_bus_mode_i,
bus_scheme_select_i,shared_strobe_pin_i,wr_n_i,scheme_o,addr_valid_o,
data_strobe_o,input wire [7:0] ad_i,reg_addr_o,reg_data_o);
default clocking @(posedge mclk_i); endclocking
default disable iff (!rst_n_i);
wire ind=scheme_o&shared_strobe_pin_i;
a_latch_addr: assert property (!scheme_o&&$fell(shared_strobe_pin_i)
|=> reg_addr_o==$past(ad_i)) else $error("latch addr");
a_ind_addr: assert property (ind&&$rose(wr_n_i)
|=> reg_addr_o==$past(ad_i)) else $error("ind addr");
a_data_take: assert property (split_bus_mode_i&&!ind&&$rose(wr_n_i)
|=> data_strobe_o&&reg_data_o==$past(ad_i)) else $error("data");
a_addr_kept: assert property (data_strobe_o&&scheme_o
|-> $stable(reg_addr_o)) else $error("addr kept");
a_strap_take: assert property ($past(rst_n_i)&&!$past(rst_n_i,2)
|-> scheme_o==$past(bus_scheme_select_i)) else $error("strap");
cover property (data_strobe_o);
cover property (ind&&$rose(wr_n_i));
cover property (!scheme_o&&$fell(shared_strobe_pin_i));
endmodule
bind sbd_decode sbd_chk u_chk(.*);

// file: sbd_host.sv
`timescale 1ns/1ps
module sbd_host(input wire mclk_i,output reg st_o=1'h1,
output reg wr_n_o=1'h1,output reg [7:0] ad_o=8'h00);
task op(input m,a,input [7:0] d);
begin
   @(negedge mclk_i) ad_o=d;
   st_o=m?a:a|st_o;
   wr_n_o=a&~m;
   @(negedge mclk_i) st_o=m?a:st_o&~a;
   wr_n_o=1'h1;
   // released bus shows the inverse
   @(negedge mclk_i) ad_o=~d;
end
endtask
endmodule

// file: sbd_decode_test.sv
`timescale 1ns/1ps
module sbd_decode_test;
reg mclk_i=0,rst_n_i=0,sp=1,sel=0,a,va;
reg [16:0] r=17'h1_2741;
reg [7:0] ea,ed;
integer bad_count=0,samples_checked=0,i,s,nd=0,ne=0;
wire st,wr_n,sc,av,ds;
wire [7:0] ad,ra,rd;
sbd_host h(.mclk_i(mclk_i),.st_o(st),.wr_n_o(wr_n),.ad_o(ad));
sbd_decode DUT(.mclk_i(mclk_i),.rst_n_i(rst_n_i),.split_bus_mode_i(sp),
.bus_scheme_select_i(sel),.shared_strobe_pin_i(st),.wr_n_i(wr_n),
.ad_i(ad),.scheme_o(sc),.reg_addr_o(ra),.addr_valid_o(av),
.reg_data_o(rd),.data_strobe_o(ds));
// count data strobes seen, one per accepted data byte
always @(posedge mclk_i) if(ds) nd<=nd+1;
function [16:0] lf(input [16:0] v);
lf={v[15:0],v[16]^v[13]};
endfunction
always #2.5 mclk_i=~mclk_i;
task chk(input [7:0] g,e);
begin
   samples_checked=samples_checked+1;
   bad_count=bad_count+(g!==e);
   if(g!==e) $display("[FAIL] %0t %h %h",$time,g,e);
end
endtask
task stop_test;
begin
   $display("%0d bad of %0d",bad_count,samples_checked);
   if(bad_count==0&&samples_checked>0) $display("bench passed");
   else $display("bench failed");
   $finish;
end
endtask
initial
begin
   #20000 bad_count=bad_count+1;
   stop_test;
end
initial
begin
   for(s=0;s<2;s=s+1)
   begin
      rst_n_i=0;
      sel=s[0];
      ea=8'h00;
      ed=8'h00;
      va=1'b0;
      repeat(20) @(negedge mclk_i);
      rst_n_i=1;
      @(negedge mclk_i) chk(sc,sel);
      // two addresses back to back open each phase
      for(i=0;i<40;i=i+1)
      begin
         r=lf(r);
         a=r[8]|i<2;
         sp=~sel|r[9];
         h.op(sel,a,r[7:0]);
         ea=a?r[7:0]:ea;
         ed=!a&&sp?r[7:0]:ed;
         va=va|a;
         ne=ne+(!a&&sp);
         @(negedge mclk_i) chk(ra,ea);
         chk(rd,ed);
         chk({7'h00,av},{7'h00,va});
      end
      chk(nd[7:0],ne[7:0]);
   end
   stop_test;
end
endmodule
